/* pkg/scoc_regs.svh */
/*
  Constants for the stream configuration and overlay command block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SCOC_REGS_SVH
`define SCOC_REGS_SVH
`define SCOC_OP_CFG_STREAM   8'h51
`define SCOC_OP_OVERLAY      8'hb1
`define SCOC_SUB_RESTORE     8'hc0
`define SCOC_SUB_FREEZE      8'hc1
`define SCOC_SUB_IDENTIFY    8'hc2
`define SCOC_SUB_SET         8'hc3
`define SCOC_FEAT_ADD_BIT    7
`define SCOC_FEAT_DIR_BIT    6
`define SCOC_FEAT_ID_MSB     2
`define SCOC_ERR_ABORT       8'h04
`define SCOC_STS_RDY         8'h40
`define SCOC_STS_DRQ         8'h08
`define SCOC_STS_ERR         8'h01
`define SCOC_STS_BSY         8'h80
`define SCOC_IDENT_WORDS     9'h100
`define SCOC_IDENT_LAST      9'h0ff
`define SCOC_REJ_REASON      8'h01
`define SCOC_REJ_WORD        8'h07
`define SCOC_REJ_BIT         8'h00
`endif

/* pkg/scoc_pkg.sv */
/*
  Types for the stream configuration and overlay command block.
  Assumes nothing of its surroundings.
*/
package scoc_pkg;
  typedef enum logic [2:0] {
    SCOC_IDLE,
    SCOC_EXEC,
    SCOC_XFER,
    SCOC_DONE
  } scoc_state_t;
endpackage : scoc_pkg

/* verilog/scoc_cmd.sv */
/*
  Command interpreter for stream configuration (51h) and the configuration
  overlay command (B1h). Assumes the host has loaded the task-file bytes when
  cmd_write pulses, and that por_n falls only at power removal.
*/
// Operation
// - Opcode 51h configures the one stream named in the feature byte.
// - Feature bit 7 set adds a stream; clear removes one.
// - Feature bit 6 clear is a read stream, set a write stream.
// - Adding a valid identifier overwrites it; abort keeps old values.
// - Abort without streaming support or when removing an unknown identifier.
// - Default time limit is previous feature times identify words 99:98, in us.
// - Time limit runs from command write to final completion interrupt.
// - A requested limit under the minimum takes the minimum; code clamps only the default, a non-zero lookup_limit passes unclamped.
// - Allocation unit is 16 bits: current count low, previous count high.
// - Opcode B1h feature C0h restore, C1h freeze, C2h identify, C3h set.
// - Restore cancels all set reductions; identify device shows full set.
// - After freeze lock every later overlay subcommand aborts.
// - Freeze lock survives hardware and software reset; only power-down clears.
// - Overlay identify returns 512 bytes by PIO data-in.
// - After set, identify device shows reduced set; overlay identify full set.
// - A rejected set reports reason, word index and bit location; code leaves them unchanged when the set aborts under freeze lock.
`timescale 1ns/1ps
`default_nettype none
`include "scoc_regs.svh"
module scoc_cmd #(
  parameter int ID_W   = 3,
  parameter int CAP_W  = 16,
  parameter int UNIT_W = 32
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  por_n,
  // Command block from the host
  input  wire logic                  cmd_write,
  input  wire logic [7:0]            cmd_opcode,
  input  wire logic [7:0]            feat_cur,
  input  wire logic [7:0]            feat_prev,
  input  wire logic [7:0]            count_cur,
  input  wire logic [7:0]            count_prev,
  input  wire logic [CAP_W-1:0]      set_caps,
  // Device configuration
  input  wire logic                  stream_support,
  input  wire logic [UNIT_W-1:0]     time_unit_us,
  input  wire logic [31:0]           min_time_limit,
  input  wire logic [CAP_W-1:0]      full_caps,
  input  wire logic [15:0]           ident_word,
  // Streaming command lookup
  input  wire logic [ID_W-1:0]       lookup_id,
  input  wire logic [31:0]           lookup_limit,
  output logic [31:0]                completion_time_limit,
  output logic                       lookup_valid,
  output logic                       lookup_dir,
  output logic [15:0]                lookup_unit,
  // Results to the host
  output logic [7:0]                 status_reg,
  output logic [7:0]                 error_reg,
  output logic [7:0]                 reason_reg,
  output logic [7:0]                 word_loc_reg,
  output logic [7:0]                 bit_loc_reg,
  output logic                       intrq,
  output logic                       pio_valid,
  output logic [15:0]                pio_data,
  output logic [8:0]                 pio_index,
  input  wire logic                  pio_ready,
  output logic [CAP_W-1:0]           ident_caps,
  output logic                       freeze_lock
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] clamp_limit(input logic [31:0] req, input logic [31:0] mn);
    clamp_limit = (req < mn) ? mn : req;
  endfunction : clamp_limit

  scoc_pkg::scoc_state_t state_reg;
  logic [7:0]            op_reg;
  logic [7:0]            fc_reg;
  logic [7:0]            fp_reg;
  logic [15:0]           unit_reg;
  logic [CAP_W-1:0]      caps_reg;
  logic                  abort_w;
  logic [ID_W-1:0]       sid;
  logic [UNIT_W+7:0]     prod;
  logic [7:0]            sub_w;
  logic [ID_W-1:0]       sid_reg;
  logic [(1<<ID_W)-1:0]  valid_reg;
  logic [(1<<ID_W)-1:0]  dir_reg;
  logic [31:0]           limit_reg [(1<<ID_W)];
  logic [15:0]           alloc_reg [(1<<ID_W)];
  logic                  bad_set;
  logic                  is_stream;

  assign sid       = fc_reg[`SCOC_FEAT_ID_MSB:0];
  assign is_stream = (op_reg == `SCOC_OP_CFG_STREAM);
  assign sub_w     = fc_reg;
  assign prod      = fp_reg * time_unit_us;
  assign bad_set   = |(caps_reg & ~full_caps);

  // ----------------------------------------------------------------------
  // Abort decision
  // ----------------------------------------------------------------------
  always_comb
  begin
    abort_w = 1'b0;
    if (is_stream)
    begin
      if (!stream_support)
        abort_w = 1'b1;
      else if (!fc_reg[`SCOC_FEAT_ADD_BIT] && !valid_reg[sid])
        abort_w = 1'b1;
    end
    else
    begin
      if (freeze_lock)
        abort_w = 1'b1;
      else if (sub_w < `SCOC_SUB_RESTORE || sub_w > `SCOC_SUB_SET)
        abort_w = 1'b1;
      else if (sub_w == `SCOC_SUB_SET && bad_set)
        abort_w = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= scoc_pkg::SCOC_IDLE;
      op_reg    <= 8'h00;
      fc_reg    <= 8'h00;
      fp_reg    <= 8'h00;
      unit_reg  <= 16'h0000;
      caps_reg  <= '0;
      pio_index <= 9'h000;
    end
    else
    begin
      case (state_reg)
        scoc_pkg::SCOC_IDLE:
          if (cmd_write && (cmd_opcode == `SCOC_OP_CFG_STREAM || cmd_opcode == `SCOC_OP_OVERLAY))
          begin
            op_reg    <= cmd_opcode;
            fc_reg    <= feat_cur;
            fp_reg    <= feat_prev;
            unit_reg  <= {count_prev, count_cur};
            caps_reg  <= set_caps;
            state_reg <= scoc_pkg::SCOC_EXEC;
          end
        scoc_pkg::SCOC_EXEC:
        begin
          pio_index <= 9'h000;
          if (!abort_w && !is_stream && sub_w == `SCOC_SUB_IDENTIFY)
            state_reg <= scoc_pkg::SCOC_XFER;
          else
            state_reg <= scoc_pkg::SCOC_DONE;
        end
        scoc_pkg::SCOC_XFER:
          if (pio_ready)
          begin
            pio_index <= pio_index + 9'h001;
            if (pio_index == `SCOC_IDENT_LAST)
              state_reg <= scoc_pkg::SCOC_DONE;
          end
        scoc_pkg::SCOC_DONE:
          state_reg <= scoc_pkg::SCOC_IDLE;
        default:
          state_reg <= scoc_pkg::SCOC_IDLE;
      endcase
    end
  end

  assign pio_valid = (state_reg == scoc_pkg::SCOC_XFER);
  assign pio_data  = ident_word;

  // ----------------------------------------------------------------------
  // Stream table; untouched on abort
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      valid_reg <= '0;
      dir_reg   <= '0;
      for (int i = 0; i < (1<<ID_W); i++)
      begin
        limit_reg[i] <= 32'h0000_0000;
        alloc_reg[i] <= 16'h0000;
      end
    end
    else if (state_reg == scoc_pkg::SCOC_EXEC && is_stream && !abort_w)
    begin
      valid_reg[sid] <= fc_reg[`SCOC_FEAT_ADD_BIT];
      if (fc_reg[`SCOC_FEAT_ADD_BIT])
      begin
        dir_reg[sid]   <= fc_reg[`SCOC_FEAT_DIR_BIT];
        limit_reg[sid] <= clamp_limit(prod[31:0], min_time_limit);
        alloc_reg[sid] <= unit_reg;
      end
    end
  end

  assign lookup_valid = valid_reg[lookup_id];
  assign lookup_dir   = dir_reg[lookup_id];
  assign lookup_unit  = alloc_reg[lookup_id];
  // Limit applied from the command write to its final interrupt
  assign completion_time_limit = (lookup_limit == 32'h0000_0000) ? limit_reg[lookup_id]
                                 : lookup_limit;

  // ----------------------------------------------------------------------
  // Overlay state; freeze lock cleared only by power-on reset
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      freeze_lock <= 1'b0;
    else if (state_reg == scoc_pkg::SCOC_EXEC && !is_stream && !abort_w && sub_w == `SCOC_SUB_FREEZE)
      freeze_lock <= 1'b1;
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      ident_caps <= '1;
    else if (state_reg == scoc_pkg::SCOC_EXEC && !is_stream && !abort_w)
    begin
      if (sub_w == `SCOC_SUB_RESTORE)
        ident_caps <= full_caps;
      else if (sub_w == `SCOC_SUB_SET)
        ident_caps <= caps_reg & full_caps;
    end
  end

  // ----------------------------------------------------------------------
  // Completion status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_reg   <= `SCOC_STS_RDY;
      error_reg    <= 8'h00;
      reason_reg   <= 8'h00;
      word_loc_reg <= 8'h00;
      bit_loc_reg  <= 8'h00;
      intrq        <= 1'b0;
    end
    else
    begin
      intrq <= 1'b0;
      if (state_reg == scoc_pkg::SCOC_IDLE && cmd_write
          && (cmd_opcode == `SCOC_OP_CFG_STREAM || cmd_opcode == `SCOC_OP_OVERLAY))
        status_reg <= `SCOC_STS_BSY;
      else if (state_reg == scoc_pkg::SCOC_EXEC)
      begin
        if (abort_w)
        begin
          status_reg <= `SCOC_STS_RDY | `SCOC_STS_ERR;
          error_reg  <= `SCOC_ERR_ABORT;
          intrq      <= 1'b1;
          if (!is_stream && !freeze_lock && sub_w == `SCOC_SUB_SET)
          begin
            reason_reg   <= `SCOC_REJ_REASON;
            word_loc_reg <= `SCOC_REJ_WORD;
            bit_loc_reg  <= `SCOC_REJ_BIT;
          end
        end
        else if (!is_stream && sub_w == `SCOC_SUB_IDENTIFY)
        begin
          status_reg <= `SCOC_STS_RDY | `SCOC_STS_DRQ;
          error_reg  <= 8'h00;
          intrq      <= 1'b1;
        end
        else
        begin
          status_reg <= `SCOC_STS_RDY;
          error_reg  <= 8'h00;
          intrq      <= 1'b1;
        end
      end
      else if (state_reg == scoc_pkg::SCOC_XFER && pio_ready && pio_index == `SCOC_IDENT_LAST)
        status_reg <= `SCOC_STS_RDY;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_freeze_blocks: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_EXEC && op_reg == `SCOC_OP_OVERLAY && freeze_lock)
      |=> (error_reg == `SCOC_ERR_ABORT && status_reg[0]))
    else $error("overlay command not aborted under freeze lock");
  a_remove_unknown: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_EXEC && is_stream && !fc_reg[`SCOC_FEAT_ADD_BIT] && !valid_reg[sid])
      |=> (error_reg == `SCOC_ERR_ABORT))
    else $error("removal of unknown stream not aborted");
  a_abort_keeps: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_EXEC && abort_w) |=> $stable(valid_reg))
    else $error("abort changed stream table");
  a_add_sets_valid: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_EXEC && is_stream && !abort_w && fc_reg[`SCOC_FEAT_ADD_BIT])
      |=> valid_reg[$past(sid)])
    else $error("add did not mark stream valid");
  a_limit_floor: assert property (@(posedge clk) disable iff (!resetn)
    (lookup_valid && lookup_limit == 32'h0000_0000) |-> completion_time_limit >= min_time_limit)
    else $error("default time limit below minimum");
  a_reserved_abort: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_EXEC && !is_stream && (fc_reg < `SCOC_SUB_RESTORE || fc_reg > `SCOC_SUB_SET))
      |=> (status_reg[0] && intrq))
    else $error("reserved subcommand not aborted");
  a_ident_len: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == scoc_pkg::SCOC_XFER) |-> pio_index <= 9'h0ff)
    else $error("identify transfer overran 256 words");
  a_abort_status: assert property (@(posedge clk) disable iff (!resetn)
    (intrq && error_reg[2]) |-> (status_reg[0] && !status_reg[7]))
    else $error("abort status wrong");
endmodule : scoc_cmd
`default_nettype wire

/* sim/scoc_host.sv */
/*
  Host controller model: writes command blocks and drains identify data.
  Assumes a free-running clock and a device that answers with intrq.
*/
`timescale 1ns/1ps
`default_nettype none
module scoc_host (
  // Clock and device answers
  input  wire logic        clk,
  input  wire logic        intrq,
  input  wire logic        pio_valid,
  input  wire logic [8:0]  pio_index,
  input  wire logic [15:0] pio_data,
  // Command block
  output logic             cmd_write,
  output logic [7:0]       cmd_opcode,
  output logic [7:0]       feat_cur,
  output logic [7:0]       feat_prev,
  output logic [7:0]       count_cur,
  output logic [7:0]       count_prev,
  output logic [15:0]      set_caps,
  // Data-in drain
  output logic             pio_ready,
  output int               words,
  output int               skips
);
  initial
  begin
    cmd_write = 1'b0;
    {cmd_opcode, feat_cur, feat_prev, count_cur, count_prev, set_caps} = '0;
    pio_ready = 1'b0;
    words = 0;
    skips = 0;
  end

  // Bytes held over the taking edge, then flipped once released
  task automatic issue(input logic [7:0] op, fc, fp, cc, cp, input logic [15:0] caps, output int at);
    at = 0;
    @(posedge clk) #1;
    {cmd_opcode, feat_cur, feat_prev, count_cur, count_prev, set_caps} = {op, fc, fp, cc, cp, caps};
    cmd_write = 1'b1;
    @(posedge clk) #1;
    cmd_write = 1'b0;
    {cmd_opcode, feat_cur, feat_prev, count_cur, count_prev, set_caps} =
      ~{cmd_opcode, feat_cur, feat_prev, count_cur, count_prev, set_caps};
    for (int i = 1; i <= 4; i++)
    begin
      @(posedge clk) #1;
      if (intrq === 1'b1)
        at = i;
    end
  endtask : issue

  // Stalls one cycle in three while taking words
  task automatic drain();
    words = 0;
    skips = 0;
    for (int c = 0; c < 700; c++)
    begin
      @(posedge clk) #1;
      pio_ready = (c % 3 != 2);
      @(negedge clk);
      if (pio_valid === 1'b1 && pio_ready)
      begin
        if (pio_index !== words[8:0] || pio_data !== ({7'h00, words[8:0]} ^ 16'h5a00))
          skips++;
        words++;
      end
    end
    @(posedge clk) #1;
    pio_ready = 1'b0;
  endtask : drain
endmodule : scoc_host
`default_nettype wire

/* sim/testbench.sv */
/*
  Self-checking bench for the stream and overlay command block.
  Assumes the host model drives the command block and drains data.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, resetn, por_n, stream_support, cmd_write, pio_ready;
  logic [7:0]  cmd_opcode, feat_cur, feat_prev, count_cur, count_prev;
  logic [7:0]  status_reg, error_reg, reason_reg, word_loc_reg, bit_loc_reg;
  logic [15:0] set_caps, full_caps, ident_word, lookup_unit, pio_data, ident_caps;
  logic [31:0] time_unit_us, min_time_limit, lookup_limit, completion_time_limit;
  logic [2:0]  lookup_id;
  logic [8:0]  pio_index;
  logic        lookup_valid, lookup_dir, intrq, pio_valid, freeze_lock;
  int          fails, checked, words, skips;

  assign ident_word = {7'h00, pio_index} ^ 16'h5a00;

  scoc_cmd scoc_cmd_i (.clk(clk), .resetn(resetn), .por_n(por_n), .cmd_write(cmd_write),
    .cmd_opcode(cmd_opcode), .feat_cur(feat_cur), .feat_prev(feat_prev), .count_cur(count_cur),
    .count_prev(count_prev), .set_caps(set_caps), .stream_support(stream_support),
    .time_unit_us(time_unit_us), .min_time_limit(min_time_limit), .full_caps(full_caps),
    .ident_word(ident_word), .lookup_id(lookup_id), .lookup_limit(lookup_limit),
    .completion_time_limit(completion_time_limit), .lookup_valid(lookup_valid),
    .lookup_dir(lookup_dir), .lookup_unit(lookup_unit), .status_reg(status_reg),
    .error_reg(error_reg), .reason_reg(reason_reg), .word_loc_reg(word_loc_reg),
    .bit_loc_reg(bit_loc_reg), .intrq(intrq), .pio_valid(pio_valid), .pio_data(pio_data),
    .pio_index(pio_index), .pio_ready(pio_ready), .ident_caps(ident_caps), .freeze_lock(freeze_lock));

  scoc_host scoc_host_i (.clk(clk), .intrq(intrq), .pio_valid(pio_valid), .pio_index(pio_index),
    .pio_data(pio_data),
    .cmd_write(cmd_write), .cmd_opcode(cmd_opcode), .feat_cur(feat_cur), .feat_prev(feat_prev),
    .count_cur(count_cur), .count_prev(count_prev), .set_caps(set_caps), .pio_ready(pio_ready),
    .words(words), .skips(skips));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op, fc, fp, cc, cp, input logic [15:0] caps, input logic [7:0] st, er);
    int at;
    scoc_host_i.issue(op, fc, fp, cc, cp, caps, at);
    chk(at, 1, "intrq cycle");
    chk(status_reg, st, "status");
    chk(error_reg, er, "error");
  endtask : cmd

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {resetn, por_n, stream_support} = 3'b000;
    time_unit_us = 32'h0000000a;
    min_time_limit = 32'h00000014;
    full_caps = 16'h7fff;
    lookup_id = 3'h5;
    lookup_limit = 32'h00000000;
    repeat (6) @(posedge clk);
    #1 {resetn, por_n} = 2'b11;
    chk(status_reg, 8'h40, "reset status");
    chk(ident_caps, 16'hffff, "power-on caps");
    cmd(8'h51, 8'hc2, 8'h01, 8'h00, 8'h00, 16'h0000, 8'h41, 8'h04);
    stream_support = 1'b1;
    cmd(8'h51, 8'h03, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h41, 8'h04);
    cmd(8'h51, 8'hc5, 8'h03, 8'h34, 8'h12, 16'h0000, 8'h40, 8'h00);
    chk(completion_time_limit, 32'h1e, "default limit");
    chk(lookup_valid, 1'b1, "added");
    chk(lookup_dir, 1'b1, "write stream");
    chk(lookup_unit, 16'h1234, "alloc unit");
    lookup_limit = 32'h7;
    #1 chk(completion_time_limit, 32'h7, "explicit limit");
    lookup_limit = 32'h0;
    cmd(8'h51, 8'h85, 8'h01, 8'h78, 8'h56, 16'h0000, 8'h40, 8'h00);
    chk(completion_time_limit, 32'h14, "clamped limit");
    chk(lookup_dir, 1'b0, "read stream");
    chk(lookup_unit, 16'h5678, "overwritten unit");
    stream_support = 1'b0;
    cmd(8'h51, 8'hc5, 8'h09, 8'h00, 8'h00, 16'h0000, 8'h41, 8'h04);
    chk(completion_time_limit, 32'h14, "kept limit");
    stream_support = 1'b1;
    cmd(8'h51, 8'h05, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h40, 8'h00);
    chk(lookup_valid, 1'b0, "removed");
    cmd(8'hb1, 8'hc4, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h41, 8'h04);
    cmd(8'hb1, 8'hc3, 8'h00, 8'h00, 8'h00, 16'h00ff, 8'h40, 8'h00);
    chk(ident_caps, 16'h00ff, "reduced caps");
    cmd(8'hb1, 8'hc3, 8'h00, 8'h00, 8'h00, 16'h8000, 8'h41, 8'h04);
    chk({reason_reg, word_loc_reg, bit_loc_reg}, 24'h010700, "set reject");
    cmd(8'hb1, 8'hc2, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h48, 8'h00);
    scoc_host_i.drain();
    chk(words, 256, "identify words");
    chk(skips, 0, "identify order");
    chk(status_reg, 8'h40, "identify end");
    chk(ident_caps, 16'h00ff, "caps after identify");
    cmd(8'hb1, 8'hc0, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h40, 8'h00);
    chk(ident_caps, 16'h7fff, "restored caps");
    cmd(8'hb1, 8'hc1, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h40, 8'h00);
    chk(freeze_lock, 1'b1, "frozen");
    for (int i = 0; i < 4; i++)
      cmd(8'hb1, 8'hc0 + i[7:0], 8'h00, 8'h00, 8'h00, 16'h0001, 8'h41, 8'h04);
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    chk(freeze_lock, 1'b1, "lock kept");
    chk(status_reg, 8'h40, "status after reset");
    por_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 por_n = 1'b1;
    chk(freeze_lock, 1'b0, "lock cleared");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
